/* core/asf_consts.svh */
// constants for the converter status flag block
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH
// channel count and result width
`define ASF_NUM_CH 8
`define ASF_CH_W 3
`define ASF_DATA_W 10
// register byte offsets
`define ASF_OFF_CTRL 8'h00
`define ASF_OFF_MODE 8'h04
`define ASF_OFF_CHEN 8'h08
`define ASF_OFF_STATUS 8'h0C
`define ASF_OFF_LAST 8'h10
`define ASF_OFF_IRQ_ST 8'h14
`define ASF_OFF_IRQ_MASK 8'h18
`define ASF_OFF_RESULT0 8'h20
`define ASF_OFF_RESULT_LAST 8'h3C
// status field positions
`define ASF_POS_DONE 0
`define ASF_POS_OVR 8
`define ASF_POS_READY 16
`define ASF_POS_GLOB_OVR 17
`define ASF_POS_BUSY 18
`define ASF_POS_SLEEP 19
// last result field position of the channel number
`define ASF_POS_LAST_CH 12
// interrupt bits
`define ASF_IRQ_EOC 0
`define ASF_IRQ_OVR 1
`define ASF_IRQ_W 2
// reset values
`define ASF_RST_CHEN 8'h00
`define ASF_RST_IRQ_MASK 2'h0
`endif

/* core/asf_pkg.sv */
// types of the converter status flag block
`include "asf_consts.svh"
package asf_pkg;
   typedef logic [`ASF_NUM_CH-1:0] asf_chmask_t;
   typedef logic [`ASF_DATA_W-1:0] asf_data_t;
   typedef logic [`ASF_CH_W-1:0] asf_ch_t;
   // one end of conversion from the analog front end
   typedef struct packed {
      logic eoc;
      asf_ch_t ch;
      asf_data_t data;
   } asf_conv_s;
   // state of the main block
   typedef struct packed {
      asf_chmask_t done;
      asf_chmask_t ovr;
      logic data_ready_flag;
      logic global_overrun_flag;
      asf_data_t last_data;
      asf_ch_t last_ch;
      logic [`ASF_NUM_CH-1:0][`ASF_DATA_W-1:0] results;
      asf_chmask_t chen;
      logic sleep_sel;
      logic start_req;
      logic [`ASF_IRQ_W-1:0] irq_st;
      logic [`ASF_IRQ_W-1:0] irq_mask;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] hrdata;
   } asf_state_s;
   // state of the sleep sequencer
   typedef struct packed {
      logic busy;
      logic sleep;
      logic conv_start;
   } asf_seq_s;
endpackage : asf_pkg

/* core/asf_sleep_seq.sv */
// conversion start and deferred sleep sequencer
`timescale 1ns/1ps
`include "asf_consts.svh"
module asf_sleep_seq (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // control from the register file, and the end of conversion from the converter
   input wire logic start_req,
   input wire logic sleep_sel,
   input wire logic conv_eoc,
   // to the converter and the status register
   output logic conv_start,
   output logic conv_busy,
   output logic sleep_active
);
   import asf_pkg::*;
   asf_seq_s s_r, s_nxt;

   // a start while busy is dropped; sleep is only entered at a conversion end
   always_comb begin
      s_nxt = s_r;
      s_nxt.conv_start = 1'b0;
      if (start_req && !s_r.busy) begin
         s_nxt.conv_start = 1'b1;
         s_nxt.busy = 1'b1;
         s_nxt.sleep = 1'b0; // waking for a start
      end else if (conv_eoc) begin
         s_nxt.busy = 1'b0;
         s_nxt.sleep = sleep_sel; // selecting sleep while idle waits for this edge
      end
      if (!sleep_sel) begin
         s_nxt.sleep = 1'b0;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign conv_start = s_r.conv_start;
   assign conv_busy = s_r.busy;
   assign sleep_active = s_r.sleep;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_end_in_sleep;
      conv_eoc && sleep_sel && !start_req;
   endsequence
   property p_sleep_after_conv;
      s_end_in_sleep |=> sleep_active;
   endproperty
   a_sleep_after_conv: assert property (p_sleep_after_conv)
      else $error("sleep not entered at conversion end");
   property p_sleep_only_at_end;
      $rose(sleep_active) |-> $past(conv_eoc);
   endproperty
   a_sleep_only_at_end: assert property (p_sleep_only_at_end)
      else $error("sleep entered without a conversion end");
endmodule : asf_sleep_seq

/* core/asf_flags.sv */
// converter status flags with ahb-lite register slave and interrupt
// Contract
// - data ready clears only on a last result read, not on channel reads.
// - a channel read, or last read holding that channel, clears its done flag.
// - a stored conversion writes channel and last result, sets done and ready.
// - a conversion ending with data ready already set sets global overrun.
// - a status read clears global overrun unless a new overrun arrives.
// - status read with conversion end: global overrun equals prior data ready.
// - a conversion ending on a channel still done sets its overrun flag.
// - a status read clears channel overruns even when done sets that cycle.
// - disabling another channel never spoils ready or global overrun updates.
// - a channel disabled during conversion never gets its done flag set.
// - data ready rises only when a result is really stored.
// - a channel read clears only that channel's done flag.
// - sleep chosen while idle starts only after the next conversion ends.
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "asf_consts.svh"
module asf_flags (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // converter front end
   input wire asf_pkg::asf_conv_s conv_in,
   output logic conv_start,
   output logic sleep_active,
   // interrupt
   output logic irq
);
   import asf_pkg::*;

   asf_state_s s_r, s_nxt;
   logic acc;
   logic rd;
   logic [7:0] a;
   logic store;
   logic sr_rd;
   logic last_rd;
   logic irq_rd;
   asf_chmask_t res_rd;
   asf_chmask_t done_clr;
   asf_chmask_t done_set;
   asf_chmask_t ovr_set;
   logic conv_busy;

   // address phase decode; zero wait states, so every accepted phase is final
   assign acc = hsel && htrans[1] && hready;
   assign rd = acc && !hwrite;
   assign a = haddr[7:0];
   assign sr_rd = rd && (a == `ASF_OFF_STATUS);
   assign last_rd = rd && (a == `ASF_OFF_LAST);
   assign irq_rd = rd && (a == `ASF_OFF_IRQ_ST);

   // only an enabled channel stores; the enable of other channels plays no part
   assign store = conv_in.eoc && s_r.chen[conv_in.ch];

   // per channel read decode, clear and set terms
   genvar gi;
   generate
      for (gi = 0; gi < `ASF_NUM_CH; gi++) begin : g_ch
         localparam logic [7:0] OFF = 8'(`ASF_OFF_RESULT0 + 4 * gi);
         assign res_rd[gi] = rd && (a == OFF);
         // clear follows the channel actually read
         assign done_clr[gi] = res_rd[gi] || (last_rd && (s_r.last_ch == asf_ch_t'(gi)));
         assign done_set[gi] = store && (conv_in.ch == asf_ch_t'(gi));
         assign ovr_set[gi] = done_set[gi] && s_r.done[gi];
      end
   endgenerate

   // next state: bus, registers and flags
   always_comb begin
      s_nxt = s_r;
      s_nxt.start_req = 1'b0;
      s_nxt.dp_wr = acc && hwrite;
      s_nxt.dp_addr = a;
      // read data is sampled before any clear-on-read of the same access
      if (rd) begin
         s_nxt.hrdata = 32'h0000_0000;
         case (a)
            `ASF_OFF_MODE: s_nxt.hrdata[0] = s_r.sleep_sel;
            `ASF_OFF_CHEN: s_nxt.hrdata[`ASF_NUM_CH-1:0] = s_r.chen;
            `ASF_OFF_STATUS: begin
               s_nxt.hrdata[`ASF_POS_DONE+:`ASF_NUM_CH] = s_r.done;
               s_nxt.hrdata[`ASF_POS_OVR+:`ASF_NUM_CH] = s_r.ovr;
               s_nxt.hrdata[`ASF_POS_READY] = s_r.data_ready_flag;
               s_nxt.hrdata[`ASF_POS_GLOB_OVR] = s_r.global_overrun_flag;
               s_nxt.hrdata[`ASF_POS_BUSY] = conv_busy;
               s_nxt.hrdata[`ASF_POS_SLEEP] = sleep_active;
            end
            `ASF_OFF_LAST: begin
               s_nxt.hrdata[`ASF_DATA_W-1:0] = s_r.last_data;
               s_nxt.hrdata[`ASF_POS_LAST_CH+:`ASF_CH_W] = s_r.last_ch;
            end
            `ASF_OFF_IRQ_ST: s_nxt.hrdata[`ASF_IRQ_W-1:0] = s_r.irq_st;
            `ASF_OFF_IRQ_MASK: s_nxt.hrdata[`ASF_IRQ_W-1:0] = s_r.irq_mask;
            default: begin
               if (a >= `ASF_OFF_RESULT0 && a <= `ASF_OFF_RESULT_LAST && a[1:0] == 2'b00) begin
                  s_nxt.hrdata[`ASF_DATA_W-1:0] = s_r.results[a[4:2]];
               end
            end
         endcase
      end
      // writes land at the end of their data phase
      if (s_r.dp_wr) begin
         case (s_r.dp_addr)
            `ASF_OFF_CTRL: s_nxt.start_req = hwdata[0];
            `ASF_OFF_MODE: s_nxt.sleep_sel = hwdata[0];
            `ASF_OFF_CHEN: s_nxt.chen = hwdata[`ASF_NUM_CH-1:0];
            `ASF_OFF_IRQ_MASK: s_nxt.irq_mask = hwdata[`ASF_IRQ_W-1:0];
            default: s_nxt.start_req = 1'b0;
         endcase
      end
      // result storage
      if (store) begin
         s_nxt.results[conv_in.ch] = conv_in.data;
         s_nxt.last_data = conv_in.data;
         s_nxt.last_ch = conv_in.ch;
      end
      // done flags: set beats clear for the same channel
      s_nxt.done = (s_r.done & ~done_clr) | done_set;
      // channel overrun: a status read clears even as done sets
      s_nxt.ovr = (s_r.ovr & ~{`ASF_NUM_CH{sr_rd}}) | ovr_set;
      // data ready: set by a store only, cleared by a last read only
      if (store) begin
         s_nxt.data_ready_flag = 1'b1;
      end else if (last_rd) begin
         s_nxt.data_ready_flag = 1'b0;
      end
      // global overrun is always updated, never left stale by a coinciding read
      if (store && sr_rd) begin
         s_nxt.global_overrun_flag = s_r.data_ready_flag;
      end else if (store) begin
         s_nxt.global_overrun_flag = s_r.global_overrun_flag | s_r.data_ready_flag;
      end else if (sr_rd) begin
         s_nxt.global_overrun_flag = 1'b0;
      end
      // sticky interrupt status, cleared by its own read, set wins
      s_nxt.irq_st = s_r.irq_st & ~{`ASF_IRQ_W{irq_rd}};
      if (store) begin
         s_nxt.irq_st[`ASF_IRQ_EOC] = 1'b1;
      end
      if ((|ovr_set) || (store && s_r.data_ready_flag)) begin
         s_nxt.irq_st[`ASF_IRQ_OVR] = 1'b1;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.chen <= `ASF_RST_CHEN;
         s_r.irq_mask <= `ASF_RST_IRQ_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   // the start pulse and sleep entry live in the sequencer
   asf_sleep_seq u_seq (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start_req(s_r.start_req),
      .sleep_sel(s_r.sleep_sel),
      .conv_eoc(conv_in.eoc),
      .conv_start(conv_start),
      .conv_busy(conv_busy),
      .sleep_active(sleep_active)
   );

   // bus answers: always ready, always okay
   assign hrdata = s_r.hrdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // level interrupt, high while an unmasked sticky bit is set
   assign irq = |(s_r.irq_st & s_r.irq_mask);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_stored;
      store;
   endsequence
   sequence s_ready_and_done(asf_ch_t c);
      s_r.data_ready_flag && s_r.done[c];
   endsequence

   property p_ready_keep_on_res_read;
      (|res_rd) && !store && !last_rd |=> s_r.data_ready_flag == $past(s_r.data_ready_flag);
   endproperty
   a_ready_keep_on_res_read: assert property (p_ready_keep_on_res_read)
      else $error("data ready changed on a channel read");

   property p_done_clear;
      res_rd[0] && !done_set[0] |=> !s_r.done[0];
   endproperty
   a_done_clear: assert property (p_done_clear)
      else $error("done flag of channel 0 not cleared by its read");

   property p_store;
      s_stored |=> s_ready_and_done($past(conv_in.ch))
         and (s_r.last_data == $past(conv_in.data));
   endproperty
   a_store: assert property (p_store)
      else $error("conversion end not stored");

   property p_gov_set;
      store && s_r.data_ready_flag |=> s_r.global_overrun_flag;
   endproperty
   a_gov_set: assert property (p_gov_set)
      else $error("global overrun not set");

   property p_gov_read_clear;
      sr_rd && !store |=> !s_r.global_overrun_flag;
   endproperty
   a_gov_read_clear: assert property (p_gov_read_clear)
      else $error("global overrun not cleared by status read");

   property p_gov_follow;
      sr_rd && store |=> s_r.global_overrun_flag == $past(s_r.data_ready_flag);
   endproperty
   a_gov_follow: assert property (p_gov_follow)
      else $error("global overrun skipped its update");

   // a channel disable landing with a store must not spoil ready or overrun
   property p_gov_on_disable;
      store && s_r.dp_wr && (s_r.dp_addr == `ASF_OFF_CHEN) && s_r.data_ready_flag
         |=> s_r.global_overrun_flag && s_r.data_ready_flag;
   endproperty
   a_gov_on_disable: assert property (p_gov_on_disable)
      else $error("global overrun lost on a channel disable");

   property p_gov_hold;
      !store && !sr_rd && s_r.global_overrun_flag |=> s_r.global_overrun_flag;
   endproperty
   a_gov_hold: assert property (p_gov_hold)
      else $error("global overrun dropped without a status read");

   property p_ovr_set;
      store && s_r.done[conv_in.ch] |=> s_r.ovr[$past(conv_in.ch)];
   endproperty
   a_ovr_set: assert property (p_ovr_set)
      else $error("channel overrun not set");

   property p_ovr_clear;
      sr_rd && !(|ovr_set) |=> s_r.ovr == '0;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear)
      else $error("channel overrun not cleared by status read");

   // only a fresh overrun may survive a status read, even while done sets
   property p_ovr_clear_on_done;
      sr_rd |=> (s_r.ovr & ~$past(ovr_set)) == '0;
   endproperty
   a_ovr_clear_on_done: assert property (p_ovr_clear_on_done)
      else $error("stale channel overrun kept through status read");

   property p_disabled_no_done;
      conv_in.eoc && !s_r.chen[conv_in.ch] && !s_r.done[conv_in.ch]
         |=> !s_r.done[$past(conv_in.ch)];
   endproperty
   a_disabled_no_done: assert property (p_disabled_no_done)
      else $error("done set on a disabled channel");

   property p_ready_only_on_store;
      last_rd && !store |=> !s_r.data_ready_flag;
   endproperty
   a_ready_only_on_store: assert property (p_ready_only_on_store)
      else $error("data ready kept without a stored result");

   // the hazard case: a disabled channel ends while the last result is read
   property p_ready_disabled_last;
      last_rd && conv_in.eoc && !s_r.chen[conv_in.ch] |=> !s_r.data_ready_flag;
   endproperty
   a_ready_disabled_last: assert property (p_ready_disabled_last)
      else $error("data ready kept by a disabled channel end");

   property p_only_read_channel;
      (|res_rd) && !store |=> s_r.done == ($past(s_r.done) & ~$past(done_clr));
   endproperty
   a_only_read_channel: assert property (p_only_read_channel)
      else $error("wrong done flag cleared");

   // channels neither read nor stored keep their done flag, store or not
   property p_others_untouched;
      (|res_rd) |=> ((s_r.done ^ $past(s_r.done)) & ~$past(res_rd) & ~$past(done_set)) == '0;
   endproperty
   a_others_untouched: assert property (p_others_untouched)
      else $error("done flag of another channel disturbed");

   property p_done_hold;
      (|s_r.done) |=> (($past(s_r.done) & ~$past(done_clr)) & ~s_r.done) == '0;
   endproperty
   a_done_hold: assert property (p_done_hold)
      else $error("done flag dropped without a clearing read");

   property p_irq_sticky;
      store |=> s_r.irq_st[`ASF_IRQ_EOC];
   endproperty
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("conversion interrupt status not set");
endmodule : asf_flags

/* sim/adc_status_flag_logic_tb.sv */
// self-checking bench for the converter status flag block
`timescale 1ns/1ps
`include "asf_consts.svh"
module adc_status_flag_logic_tb;
   import asf_pkg::*;
   localparam logic [7:0] A_CTRL = `ASF_OFF_CTRL;
   localparam logic [7:0] A_MODE = `ASF_OFF_MODE;
   localparam logic [7:0] A_EN = `ASF_OFF_CHEN;
   localparam logic [7:0] A_ST = `ASF_OFF_STATUS;
   localparam logic [7:0] A_LAST = `ASF_OFF_LAST;
   localparam logic [7:0] A_IST = `ASF_OFF_IRQ_ST;
   localparam logic [7:0] A_IMSK = `ASF_OFF_IRQ_MASK;
   logic sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic conv_start, sleep_active, irq;
   asf_conv_s conv_in;
   int failures, n_checks, cycles, k;
   // single slave, so its ready is the bus ready
   assign hready = hreadyout;
   asf_flags u_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .conv_in(conv_in), .conv_start(conv_start),
      .sleep_active(sleep_active), .irq(irq)
   );
   // free running clock, 40 ns period
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // hang guard, far above the length of the sequence
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         end_of_test();
      end
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // one single ahb-lite transfer; an end of conversion may ride along in the
   // address phase (ph 0) or the data phase (ph 1) to make coincidences
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             input asf_conv_s cv, input logic ph);
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      hsize <= 3'b010;
      if (!ph) conv_in <= cv;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      conv_in <= ph ? cv : '0;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      if (ph) begin
         conv_in <= '0;
         @(posedge sys_clk);
      end
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] wd);
      xfer(1'b1, a, wd, '0, 1'b0);
   endtask : wr
   task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000, '0, 1'b0);
      chk(name, rd, exp);
   endtask : rdc
   function automatic logic [7:0] res(input logic [2:0] i);
      return `ASF_OFF_RESULT0 + {3'b000, i, 2'b00};
   endfunction : res
   function automatic asf_conv_s cv(input logic [2:0] c, input logic [9:0] d);
      return '{eoc: 1'b1, ch: c, data: d};
   endfunction : cv
   // lone end of conversion, then one edge so the flags land
   task eoc(input logic [2:0] c, input logic [9:0] d);
      conv_in <= cv(c, d);
      @(posedge sys_clk);
      conv_in <= '0;
      @(posedge sys_clk);
   endtask : eoc
   task do_reset;
      reset_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
   endtask : do_reset
   initial begin
      reset_n = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      conv_in = '0;
      failures = 0;
      n_checks = 0;
      cycles = 0;
      do_reset();
      // reset values and an unmapped place
      rdc("status", A_ST, 32'h0000_0000);
      rdc("chen", A_EN, 32'h0000_0000);
      rdc("mask", A_IMSK, 32'h0000_0000);
      rdc("unmapped", 8'h1C, 32'h0000_0000);
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
      wr(A_EN, 32'h0000_00FF);
      // store, then channel read keeps ready, last read clears it
      eoc(3'd2, 10'h155);
      rdc("st_store", A_ST, 32'h0001_0004);
      rdc("res2", res(3'd2), 32'h0000_0155);
      rdc("st_chread", A_ST, 32'h0001_0000);
      rdc("last", A_LAST, 32'h0000_2155);
      rdc("st_lastread", A_ST, 32'h0000_0000);
      // overruns, then status read clears both overrun kinds
      eoc(3'd1, 10'h0AA);
      eoc(3'd1, 10'h0BB);
      rdc("st_ovr", A_ST, 32'h0003_0202);
      rdc("st_ovr_clr", A_ST, 32'h0001_0002);
      rdc("last1", A_LAST, 32'h0000_10BB);
      rdc("st_idle", A_ST, 32'h0000_0000);
      rdc("irq_st", A_IST, 32'h0000_0003);
      rdc("irq_st_clr", A_IST, 32'h0000_0000);
      // status read coinciding with a store: ready active sets the global overrun
      eoc(3'd3, 10'h003);
      xfer(1'b0, A_ST, 32'h0, cv(3'd4, 10'h004), 1'b0);
      chk("st_pre", rd, 32'h0001_0008);
      rdc("st_gov_set", A_ST, 32'h0003_0018);
      rdc("st_gov_clr", A_ST, 32'h0001_0018);
      rdc("last4", A_LAST, 32'h0000_4004);
      // global overrun active with ready low, status read with a store clears it
      eoc(3'd5, 10'h005);
      eoc(3'd5, 10'h006);
      rdc("last5", A_LAST, 32'h0000_5006);
      xfer(1'b0, A_ST, 32'h0, cv(3'd6, 10'h007), 1'b0);
      chk("st_pre_drop", rd, 32'h0002_2008);
      rdc("st_gov_drop", A_ST, 32'h0001_0048);
      // channel overrun with done cleared, status read coinciding with its store
      eoc(3'd6, 10'h008);
      rdc("res6", res(3'd6), 32'h0000_0008);
      xfer(1'b0, A_ST, 32'h0, cv(3'd6, 10'h009), 1'b0);
      chk("st_ovr6", rd, 32'h0003_4008);
      rdc("st_ovr6_clr", A_ST, 32'h0003_0048);
      // disabling one channel while another stores
      do_reset();
      wr(A_EN, 32'h0000_00FF);
      xfer(1'b1, A_EN, 32'h0000_007F, cv(3'd1, 10'h011), 1'b1);
      rdc("st_dis_ready", A_ST, 32'h0001_0002);
      xfer(1'b1, A_EN, 32'h0000_003F, cv(3'd2, 10'h012), 1'b1);
      rdc("st_dis_gov", A_ST, 32'h0003_0006);
      rdc("res2_dis", res(3'd2), 32'h0000_0012);
      // disabled channel ends with a last read or a channel read
      xfer(1'b0, A_LAST, 32'h0, cv(3'd7, 10'h017), 1'b0);
      chk("last_dis", rd, 32'h0000_2012);
      rdc("st_no_ready", A_ST, 32'h0000_0002);
      xfer(1'b0, res(3'd1), 32'h0, cv(3'd7, 10'h018), 1'b0);
      chk("res1_dis", rd, 32'h0000_0011);
      rdc("st_no_done7", A_ST, 32'h0000_0000);
      // channel read of z with a store on y clears only z
      wr(A_EN, 32'h0000_00FF);
      eoc(3'd5, 10'h025);
      eoc(3'd0, 10'h020);
      xfer(1'b0, res(3'd5), 32'h0, cv(3'd1, 10'h021), 1'b0);
      chk("res5", rd, 32'h0000_0025);
      rdc("st_spur", A_ST, 32'h0003_0003);
      // interrupt masked, enabled, cleared by the interrupt status read
      do_reset();
      wr(A_EN, 32'h0000_00FF);
      eoc(3'd0, 10'h030);
      chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
      wr(A_IMSK, 32'h0000_0001);
      rdc("mask_rb", A_IMSK, 32'h0000_0001);
      chk("irq_on", {31'h0, irq}, 32'h0000_0001);
      rdc("irq_st1", A_IST, 32'h0000_0001);
      chk("irq_off", {31'h0, irq}, 32'h0000_0000);
      // deferred sleep: selected while idle, taken after the next conversion
      wr(A_MODE, 32'h0000_0001);
      repeat (4) @(posedge sys_clk);
      chk("no_sleep_idle", {31'h0, sleep_active}, 32'h0000_0000);
      wr(A_CTRL, 32'h0000_0001);
      for (k = 0; k < 4 && conv_start !== 1'b1; k++) @(posedge sys_clk);
      chk("start", {31'h0, conv_start}, 32'h0000_0001);
      rdc("st_busy", A_ST, 32'h0005_0001);
      chk("no_sleep_busy", {31'h0, sleep_active}, 32'h0000_0000);
      eoc(3'd3, 10'h033);
      for (k = 0; k < 3 && sleep_active !== 1'b1; k++) @(posedge sys_clk);
      chk("sleep", {31'h0, sleep_active}, 32'h0000_0001);
      wr(A_MODE, 32'h0000_0000);
      for (k = 0; k < 3 && sleep_active !== 1'b0; k++) @(posedge sys_clk);
      chk("wake", {31'h0, sleep_active}, 32'h0000_0000);
      end_of_test();
   end
endmodule : adc_status_flag_logic_tb
